// ==== src/fic_otp_id.sv ====
/*
  Serial flash command slice: identification reads (single, dual, quad, three-byte)
  and the three OTP arrays (program, read, erase) with lock bits and write enable.
  Assumes SPI pins arrive asynchronously and a link clock well below sys_clk/4;
  address mode, extended address byte and lock bits come from logic on sys_clk.
*/
`timescale 1ns/1ps
module fic_otp_id
  import fic_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h5a,     // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h3c,     // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h61,   // Arbitrary value
  parameter logic [7:0] CAPACITY = 8'h19,   // Arbitrary value
  parameter int ERASE_CYCLES = OTP_ERASE_CYCLES,
  parameter int PROG_CYCLES = OTP_PROG_CYCLES,
  parameter int FIFO_DEPTH = OUT_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // SPI pins
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_n,
  // Configuration
  input wire logic addr_4byte_mode,
  input wire logic [7:0] ext_addr_reg,
  input wire logic [2:0] otp_lock_bits,
  // Status
  output logic write_in_progress_flag,
  output logic write_enable_latch
);
  if (ERASE_CYCLES < 1 || PROG_CYCLES < 1 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("fic_otp_id: cycle counts must be positive and FIFO_DEPTH at least 2");
  end

  logic [5:0] pins_s;
  logic cs_n_s;
  logic sclk_s;
  logic [3:0] dq_s;
  logic sclk_d_r;
  logic cs_d_r;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;

  // Sync resets to the idle pin levels so no false link edge follows reset
  fic_sync #(.WIDTH(6), .RESET_VAL(6'h20)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in({spi_cs_n, spi_sclk, dq_in}),
    .sync_out(pins_s)
  );

  assign cs_n_s = pins_s[5];
  assign sclk_s = pins_s[4];
  assign dq_s = pins_s[3:0];
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign cs_rise = cs_n_s & ~cs_d_r;
  assign cs_fall = ~cs_n_s & cs_d_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else if (clk_en) begin
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_n_s;
    end
  end

  fic_phase_type ph_r;
  fic_op_type op_r;
  logic [7:0] cmd_r;
  logic [7:0] cmd_shift;
  logic [5:0] bit_cnt_r;
  logic [5:0] phase_len_r;
  logic [5:0] dummy_len_r;
  logic [2:0] lanes_r;
  logic [31:0] addr_r;
  logic [31:0] addr_shift;
  logic [31:0] eff_addr;
  logic [3:0] rx_bits;
  logic [7:0] din_r;
  logic [7:0] din_byte;
  logic din_done;
  logic [7:0] col_r;
  logic any_byte_r;
  logic [2:0] dec_lanes;
  logic [5:0] dec_len;
  logic [5:0] dec_dummy;
  fic_phase_type after_addr;

  assign cmd_shift = {cmd_r[6:0], dq_s[0]};
  assign din_byte = {din_r[6:0], dq_s[0]};
  assign din_done = sclk_rise && ph_r == PH_DIN && bit_cnt_r[2:0] == 3'd7;

  always_comb begin
    case (lanes_r)
      LANES_4: rx_bits = dq_s;
      LANES_2: rx_bits = {2'b00, dq_s[1:0]};
      default: rx_bits = {3'b000, dq_s[0]};
    endcase
  end
  assign addr_shift = (addr_r << lanes_r) | {28'h0000000, rx_bits};
  // Upper byte from the extended register only in 3-byte mode
  assign eff_addr = addr_4byte_mode ? addr_r : {ext_addr_reg, addr_r[23:0]};

  // Per-opcode lane count, address clocks and dummy clocks
  always_comb begin
    dec_lanes = LANES_1;
    dec_len = ADDR_BITS_3B;
    dec_dummy = 6'd0;
    case (cmd_shift)
      OP_ID_DUAL: begin
        dec_lanes = LANES_2;
        dec_len = ADDR_BITS_3B / 6'(LANES_2);
        dec_dummy = DUMMY_ID_DUAL;
      end
      OP_ID_QUAD: begin
        dec_lanes = LANES_4;
        dec_len = ADDR_BITS_3B / 6'(LANES_4);
        dec_dummy = DUMMY_ID_QUAD;
      end
      OP_OTP_PROG, OP_OTP_ERASE, OP_OTP_READ: begin
        dec_len = addr_4byte_mode ? ADDR_BITS_4B : ADDR_BITS_3B;
        dec_dummy = (cmd_shift == OP_OTP_READ) ? DUMMY_OTP_READ : 6'd0;
      end
      default: dec_len = ADDR_BITS_3B;
    endcase
  end

  always_comb begin
    if (dummy_len_r != 6'd0) begin
      after_addr = PH_DUMMY;
    end else if (cmd_r == OP_OTP_PROG) begin
      after_addr = PH_DIN;
    end else if (cmd_r == OP_OTP_ERASE) begin
      after_addr = PH_HOLD;
    end else begin
      after_addr = PH_OUT;
    end
  end

  // Command, address and dummy sequencing, sampled on link rising edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= PH_IDLE;
      cmd_r <= 8'h00;
      bit_cnt_r <= 6'd0;
      phase_len_r <= 6'd0;
      dummy_len_r <= 6'd0;
      lanes_r <= LANES_1;
      addr_r <= 32'h00000000;
      din_r <= 8'h00;
    end else if (clk_en) begin
      if (cs_n_s) begin
        ph_r <= PH_IDLE;
      end else if (cs_fall) begin
        ph_r <= PH_CMD;
        bit_cnt_r <= 6'd0;
        addr_r <= 32'h00000000;
        lanes_r <= LANES_1;
      end else if (sclk_rise) begin
        bit_cnt_r <= bit_cnt_r + 6'd1;
        case (ph_r)
          PH_CMD: begin
            cmd_r <= cmd_shift;
            if (bit_cnt_r == 6'd7) begin
              bit_cnt_r <= 6'd0;
              lanes_r <= dec_lanes;
              phase_len_r <= dec_len;
              dummy_len_r <= dec_dummy;
              // Nothing is decoded while a cycle runs; it stays untouched
              if (write_in_progress_flag) begin
                ph_r <= PH_IGNORE;
              end else begin
                case (cmd_shift)
                  OP_WREN: ph_r <= PH_HOLD;
                  OP_READ_IDENTIFICATION_CMD: ph_r <= PH_OUT;
                  OP_ID, OP_ID_DUAL, OP_ID_QUAD, OP_OTP_PROG, OP_OTP_READ,
                  OP_OTP_ERASE: ph_r <= PH_ADDR;
                  default: ph_r <= PH_IGNORE;
                endcase
              end
            end
          end
          PH_ADDR: begin
            addr_r <= addr_shift;
            if (bit_cnt_r == phase_len_r - 6'd1) begin
              bit_cnt_r <= 6'd0;
              ph_r <= after_addr;
            end
          end
          PH_DUMMY: begin
            if (bit_cnt_r == dummy_len_r - 6'd1) begin
              ph_r <= PH_OUT;
            end
          end
          PH_DIN: begin
            din_r <= din_byte;
            bit_cnt_r <= {3'b000, bit_cnt_r[2:0] + 3'd1};
          end
          // Any clock after the last address bit voids a pending erase
          PH_HOLD: ph_r <= PH_IGNORE;
          default: bit_cnt_r <= bit_cnt_r;
        endcase
      end
    end
  end

  // OTP address decode
  logic sec_hit;
  logic otp_hit;
  logic [1:0] arr_sel;
  logic [19:0] sec_off;

  assign sec_off = OTP_TOP_SECTOR - eff_addr[31:12];
  assign sec_hit = sec_off < 20'(OTP_ARRAYS);
  assign otp_hit = sec_hit && eff_addr[11:9] == 3'b000;
  assign arr_sel = sec_off[1:0];

  // Program data page, column-indexed like a page program
  logic [7:0] page_buf [0:255];
  logic [255:0] pg_mask_r;

  always_ff @(posedge sys_clk) begin
    if (clk_en && din_done) begin
      page_buf[col_r] <= din_byte;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_mask_r <= '0;
      col_r <= 8'h00;
      any_byte_r <= 1'b0;
    end else if (clk_en) begin
      if (ph_r == PH_ADDR) begin
        pg_mask_r <= '0;
        col_r <= addr_shift[7:0];
        any_byte_r <= 1'b0;
      end else if (din_done) begin
        pg_mask_r[col_r] <= 1'b1;
        col_r <= col_r + 8'd1;
        any_byte_r <= 1'b1;
      end
    end
  end

  // Self-timed program and erase cycles, write enable latch
  logic [7:0] otp_mem [0:OTP_ARRAYS*OTP_BYTES-1];
  logic [9:0] walk_r;
  logic [31:0] wait_r;
  logic [1:0] op_arr_r;
  logic op_row_r;
  logic prog_ok;
  logic erase_ok;

  // Data accepted only on deselect, complete bytes only
  assign prog_ok = cs_rise && ph_r == PH_DIN && cmd_r == OP_OTP_PROG && any_byte_r &&
                   bit_cnt_r[2:0] == 3'd0 && write_enable_latch && otp_hit &&
                   !otp_lock_bits[arr_sel];
  assign erase_ok = cs_rise && ph_r == PH_HOLD && cmd_r == OP_OTP_ERASE &&
                    write_enable_latch && sec_hit &&
                    !otp_lock_bits[arr_sel];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= OPS_IDLE;
      walk_r <= 10'd0;
      wait_r <= 32'd0;
      op_arr_r <= 2'd0;
      op_row_r <= 1'b0;
      write_in_progress_flag <= 1'b0;
      write_enable_latch <= 1'b0;
    end else if (clk_en) begin
      case (op_r)
        OPS_IDLE: begin
          if (cs_rise && ph_r == PH_HOLD && cmd_r == OP_WREN) begin
            write_enable_latch <= 1'b1;
          end
          if (prog_ok || erase_ok) begin
            op_r <= prog_ok ? OPS_PROG : OPS_ERASE;
            write_in_progress_flag <= 1'b1;
            walk_r <= 10'd0;
            op_arr_r <= arr_sel;
            op_row_r <= eff_addr[8];
          end
        end
        OPS_PROG: begin
          // Only clears bits, so unerased bytes keep their zeros
          if (pg_mask_r[walk_r[7:0]]) begin
            otp_mem[{op_arr_r, op_row_r, walk_r[7:0]}] <=
              otp_mem[{op_arr_r, op_row_r, walk_r[7:0]}] & page_buf[walk_r[7:0]];
          end
          walk_r <= walk_r + 10'd1;
          if (walk_r[7:0] == 8'hff) begin
            op_r <= OPS_WAIT;
            wait_r <= 32'(PROG_CYCLES);
          end
        end
        OPS_ERASE: begin
          otp_mem[{op_arr_r, walk_r[8:0]}] <= ERASED_BYTE;
          walk_r <= walk_r + 10'd1;
          if (walk_r[8:0] == 9'(OTP_BYTES - 1)) begin
            op_r <= OPS_WAIT;
            wait_r <= 32'(ERASE_CYCLES);
          end
        end
        OPS_WAIT: begin
          wait_r <= wait_r - 32'd1;
          if (wait_r <= 32'd1) begin
            op_r <= OPS_IDLE;
            write_in_progress_flag <= 1'b0;
            write_enable_latch <= 1'b0;
          end
        end
        default: op_r <= OPS_IDLE;
      endcase
    end
  end

  // Byte fetch into the output FIFO
  logic [7:0] fidx_r;
  logic [7:0] fetch_byte;
  logic fetch_valid;
  logic fetch_ready;
  logic [7:0] fifo_byte;
  logic fifo_valid;
  logic pop_byte;
  logic id_swap;

  assign id_swap = fidx_r[0] ^ (addr_r[23:0] == ID_SWAP_ADDR);
  assign fetch_valid = ph_r == PH_OUT && !cs_n_s;

  always_comb begin
    case (cmd_r)
      OP_READ_IDENTIFICATION_CMD: begin
        case (fidx_r)
          8'h00: fetch_byte = MFR_ID;
          8'h01: fetch_byte = MEM_TYPE;
          default: fetch_byte = CAPACITY;
        endcase
      end
      OP_OTP_READ: fetch_byte = otp_hit ? otp_mem[{arr_sel, addr_r[8], fidx_r}] : ERASED_BYTE;
      default: fetch_byte = id_swap ? DEV_ID : MFR_ID;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fidx_r <= 8'h00;
    end else if (clk_en) begin
      if (ph_r != PH_OUT) begin
        fidx_r <= (cmd_r == OP_OTP_READ) ? addr_r[7:0] : 8'h00;
      end else if (fetch_valid && fetch_ready) begin
        if (cmd_r == OP_READ_IDENTIFICATION_CMD && fidx_r == READ_IDENTIFICATION_CMD_LAST) begin
          fidx_r <= 8'h00;
        end else begin
          fidx_r <= fidx_r + 8'd1;
        end
      end
    end
  end

  // Prefetch stalls on a full FIFO; drained one byte per output byte
  fic_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .flush(cs_n_s),
    .in_valid(fetch_valid),
    .in_ready(fetch_ready),
    .in_data(fetch_byte),
    .out_valid(fifo_valid),
    .out_ready(pop_byte),
    .out_data(fifo_byte)
  );

  // Output shifter, updated on link falling edges
  logic [7:0] out_sh_r;
  logic [3:0] out_left_r;
  logic [7:0] cur_byte;

  assign pop_byte = sclk_fall && ph_r == PH_OUT && !cs_n_s && out_left_r == 4'd0;
  assign cur_byte = (out_left_r != 4'd0) ? out_sh_r : (fifo_valid ? fifo_byte : ERASED_BYTE);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_out <= 4'h0;
      dq_oe_n <= 4'hf;
      out_sh_r <= 8'h00;
      out_left_r <= 4'd0;
    end else if (clk_en) begin
      if (cs_n_s || ph_r != PH_OUT) begin
        dq_out <= 4'h0;
        dq_oe_n <= 4'hf;
        out_left_r <= 4'd0;
      end else if (sclk_fall) begin
        out_sh_r <= cur_byte << lanes_r;
        out_left_r <= ((out_left_r == 4'd0) ? 4'd8 : out_left_r) - {1'b0, lanes_r};
        case (lanes_r)
          LANES_4: begin
            dq_out <= cur_byte[7:4];
            dq_oe_n <= 4'h0;
          end
          LANES_2: begin
            dq_out <= {2'b00, cur_byte[7:6]};
            dq_oe_n <= 4'hc;
          end
          default: begin
            dq_out <= {2'b00, cur_byte[7], 1'b0};
            dq_oe_n <= 4'hd;
          end
        endcase
      end
    end
  end
endmodule // fic_otp_id

// ==== src/fic_pkg.sv ====
/*
  Shared constants and types of the flash identification and OTP command block:
  opcodes, address map of the OTP arrays, phase lengths, timing counts, state types.
  Assumes a 50 MHz system clock; no other dependency.
*/
package fic_pkg;

  // Opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_ID = 8'h90;
  localparam logic [7:0] OP_ID_DUAL = 8'h92;
  localparam logic [7:0] OP_ID_QUAD = 8'h94;
  localparam logic [7:0] OP_READ_IDENTIFICATION_CMD = 8'h9f;
  localparam logic [7:0] OP_OTP_PROG = 8'h42;
  localparam logic [7:0] OP_OTP_READ = 8'h48;
  localparam logic [7:0] OP_OTP_ERASE = 8'h44;

  // Address phase lengths in bits, dummy phases in clocks
  localparam logic [5:0] ADDR_BITS_3B = 6'd24;
  localparam logic [5:0] ADDR_BITS_4B = 6'd32;
  localparam logic [5:0] DUMMY_ID_DUAL = 6'd4;
  localparam logic [5:0] DUMMY_ID_QUAD = 6'd6;
  localparam logic [5:0] DUMMY_OTP_READ = 6'd8;
  localparam logic [2:0] LANES_1 = 3'd1;
  localparam logic [2:0] LANES_2 = 3'd2;
  localparam logic [2:0] LANES_4 = 3'd4;

  // OTP map: array 0 in sector 8191, 1 in 8190, 2 in 8189
  localparam logic [19:0] OTP_TOP_SECTOR = 20'h01fff;
  localparam int OTP_ARRAYS = 3;
  localparam int OTP_BYTES = 512;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] READ_IDENTIFICATION_CMD_LAST = 8'h02;
  localparam logic [23:0] ID_SWAP_ADDR = 24'h000001;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int OTP_ERASE_TIME_NS = 200000;
  localparam int OTP_PROG_TIME_NS = 50000;
  localparam int OTP_ERASE_CYCLES = (OTP_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OTP_PROG_CYCLES = (OTP_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OUT_FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    PH_IDLE, PH_CMD, PH_ADDR, PH_DUMMY, PH_DIN, PH_OUT, PH_HOLD, PH_IGNORE
  } fic_phase_type;

  typedef enum logic [1:0] {
    OPS_IDLE, OPS_PROG, OPS_ERASE, OPS_WAIT
  } fic_op_type;

endpackage

// ==== src/fic_sync.sv ====
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous levels; only the second stage is read outside.
*/
`timescale 1ns/1ps
module fic_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (clk_en) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // fic_sync

// ==== src/fic_fifo.sv ====
/*
  Small first-word-fall-through FIFO with valid/ready on both sides and a flush.
  Assumes flush and both handshakes are synchronous to sys_clk.
*/
`timescale 1ns/1ps
module fic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2) begin : g_bad_depth
    $error("fic_fifo needs DEPTH of at least 2");
  end

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != CW'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = store[rd_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      if (flush) begin
        wr_r <= '0;
        rd_r <= '0;
        cnt_r <= '0;
      end else begin
        if (push) begin
          wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
        end
        if (pop) begin
          rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
        end
        case ({push, pop})
          2'b10: cnt_r <= cnt_r + CW'(1);
          2'b01: cnt_r <= cnt_r - CW'(1);
          default: cnt_r <= cnt_r;
        endcase
      end
    end
  end

  // Storage needs no reset; only counted entries are ever read
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      store[wr_r] <= in_data;
    end
  end
endmodule // fic_fifo

// ==== test/fic_otp_id_sva.sv ====
/*
  Port assertions of the ID/OTP slice.
  Busy length is counted only while clk_en is high; bound to every fic_otp_id.
*/
`timescale 1ns/1ps
module fic_otp_id_sva #(
  parameter int ERASE_CYCLES = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Pins and status
  input wire logic spi_cs_n,
  input wire logic [3:0] dq_oe_n,
  input wire logic write_in_progress_flag,
  input wire logic write_enable_latch
);
  // Erase is the longest cycle: fill of 512 plus its timed wait
  localparam int BUSY_MAX = 512 + ERASE_CYCLES + 16;
  int busy_cnt_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_r <= 0;
    end else if (clk_en) begin
      busy_cnt_r <= write_in_progress_flag ? busy_cnt_r + 1 : 0;
    end
  end
  sequence s_desel; spi_cs_n [*6]; endsequence
  sequence s_busy; write_in_progress_flag [*8]; endsequence
  sequence s_start; $rose(write_in_progress_flag); endsequence
  a_idle_release: assert property (s_desel |-> dq_oe_n == 4'hf)
    else $error("lines driven while idle");
  a_drive_selected: assert property (dq_oe_n != 4'hf |-> !$past(spi_cs_n, 6))
    else $error("drive without select");
  a_busy_quiet: assert property (s_busy |-> dq_oe_n == 4'hf)
    else $error("output while busy");
  a_start_enabled: assert property (s_start |-> write_enable_latch)
    else $error("cycle without write enable");
  a_start_deselect: assert property (s_start |-> $past(spi_cs_n, 2))
    else $error("cycle started while selected");
  a_busy_min: assert property (s_start |=> s_busy)
    else $error("busy too short");
  a_busy_bound: assert property (busy_cnt_r <= BUSY_MAX)
    else $error("busy too long");
  a_end_clears_wen: assert property (
    $fell(write_in_progress_flag) |-> !write_enable_latch)
    else $error("write enable kept");
  a_wen_set_idle: assert property (
    $rose(write_enable_latch) |-> $past(spi_cs_n) && !write_in_progress_flag)
    else $error("write enable set badly");
endmodule // fic_otp_id_sva
bind fic_otp_id fic_otp_id_sva #(.ERASE_CYCLES(ERASE_CYCLES)) u_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .spi_cs_n(spi_cs_n), .dq_oe_n(dq_oe_n),
  .write_in_progress_flag(write_in_progress_flag),
  .write_enable_latch(write_enable_latch));

// ==== test/fic_host.sv ====
/*
  SPI host model for the ID/OTP slice: frames, shifts out, samples.
  Assumes split dq pins with active-low enables; link clock 160 ns, or 320 ns when slow is set.
*/
`timescale 1ns/1ps
module fic_host (
  // Pins
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic [3:0] dq_in,
  input wire logic [3:0] dq_out,
  input wire logic [3:0] dq_oe_n
);
  logic [3:0] h_en = 4'h0;
  logic [3:0] h_val = 4'h0;
  bit slow = 1'b0;
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
  end
  // Undriven lines show the inverse of their last value, not a held copy
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dq_in[i] = !dq_oe_n[i] ? dq_out[i] : h_en[i] ? h_val[i] : !h_val[i];
    end
  end
  // Select moves only with sclk low, so frames hold whole clocks
  task automatic sel(input bit on);
    h_en = 4'h0;
    spi_cs_n = !on;
    #200;
  endtask
  // No power-down command is ever issued
  task automatic xfer(input logic [31:0] v, input int n, input int ln, input bit rx,
    output logic [31:0] r);
    logic [31:0] sh;
    sh = v << (32 - n * ln);
    r = '0;
    h_en = rx ? 4'h0 : 4'hf >> (4 - ln);
    repeat (n) begin
      h_val = 4'(sh[31:28] >> (4 - ln));
      sh = sh << ln;
      #80 spi_sclk = 1'b1;
      #78;
      if (slow) #160;
      r = (r << ln) | (ln == 1 ? {31'h0, dq_in[1]} : 32'(dq_in & (4'hf >> (4 - ln))));
      #2 spi_sclk = 1'b0;
    end
  endtask
endmodule // fic_host

// ==== test/tb_top.sv ====
/*
  Bench of the ID/OTP slice: ID reads, OTP erase, program, read, locks.
  Assumes the host model on the pins and short erase/program counts.
*/
`timescale 1ns/1ps
module tb_top
  import fic_pkg::*;
;
  localparam logic [7:0] MFR = 8'ha7; // Arbitrary value
  localparam logic [7:0] DEV = 8'h4e; // Arbitrary value
  // Device defaults, left in place so only the two ID bytes are overridden
  localparam logic [7:0] MEM = 8'h61;
  localparam logic [7:0] CAP = 8'h19;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic addr_4byte_mode = 1'b0;
  logic [7:0] ext_addr_reg = 8'h01;
  logic [2:0] otp_lock_bits = 3'h0;
  logic spi_cs_n, spi_sclk, write_in_progress_flag, write_enable_latch;
  logic [3:0] dq_in, dq_out, dq_oe_n;
  logic [31:0] r;
  logic [7:0] mem [3][512];
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #10 sys_clk = ~sys_clk;
  fic_otp_id #(.MFR_ID(MFR), .DEV_ID(DEV), .ERASE_CYCLES(20), .PROG_CYCLES(10)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .addr_4byte_mode(addr_4byte_mode), .ext_addr_reg(ext_addr_reg),
    .otp_lock_bits(otp_lock_bits), .write_in_progress_flag(write_in_progress_flag),
    .write_enable_latch(write_enable_latch));
  fic_host host (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  function automatic logic [31:0] oaddr(input int a, input logic [8:0] col);
    return {20'(20'h01fff - a), 3'h0, col};
  endfunction
  function automatic int alen;
    return addr_4byte_mode ? 32 : 24;
  endfunction
  function automatic logic [15:0] id_pair(input bit sw);
    return sw ? {DEV, MFR} : {MFR, DEV};
  endfunction
  // Random address mode; the extended byte only counts in 3-byte mode
  task automatic op(input logic [7:0] code);
    logic m;
    m = 1'($urandom);
    @(posedge sys_clk);
    addr_4byte_mode <= m;
    ext_addr_reg <= m ? 8'($urandom) : 8'h01;
    // Pin moves land between sampling edges
    @(negedge sys_clk);
    host.slow = 1'($urandom);
    host.sel(1'b1);
    host.xfer(32'(code), 8, 1, 0, r);
  endtask
  task automatic wren;
    op(OP_WREN);
    host.sel(1'b0);
    chk(write_enable_latch, 1, "wen");
  endtask
  task automatic erase(input int a, input bit extra, input bit we);
    if (we) wren();
    op(OP_OTP_ERASE);
    host.xfer(oaddr(a, 9'h0), alen(), 1, 0, r);
    if (extra) host.xfer(0, 1, 1, 0, r);
    host.sel(1'b0);
  endtask
  task automatic settle(input bit busy, input bit wen);
    int n;
    chk(write_in_progress_flag, busy, "busy");
    for (n = 0; n < 2000 && write_in_progress_flag === 1'b1; n++) @(posedge sys_clk);
    #1;
    chk(write_in_progress_flag, 0, "busy end");
    chk(write_enable_latch, wen, "wen end");
  endtask
  task automatic prog(input int a, input logic [8:0] col, input int nb);
    logic [7:0] d;
    wren();
    op(OP_OTP_PROG);
    host.xfer(oaddr(a, col), alen(), 1, 0, r);
    for (int k = 0; k < nb; k++) begin
      d = 8'($urandom);
      host.xfer(32'(d), 8, 1, 0, r);
      if (!otp_lock_bits[a]) mem[a][{col[8], col[7:0] + 8'(k)}] &= d;
    end
    host.sel(1'b0);
  endtask
  task automatic rd(input int a, input logic [8:0] col);
    logic [31:0] e;
    op(OP_OTP_READ);
    host.xfer(oaddr(a, col), alen(), 1, 0, r);
    host.xfer(0, 8, 1, 0, r);
    host.xfer(0, 32, 1, 1, r);
    host.sel(1'b0);
    for (int k = 0; k < 4; k++) e = {e[23:0], mem[a][{col[8], col[7:0] + 8'(k)}]};
    chk(r, e, "otp");
  endtask
  initial begin
    logic [7:0] ids [3];
    logic [8:0] col;
    int ln;
    ids = '{OP_ID, OP_ID_DUAL, OP_ID_QUAD};
    void'($urandom(32'h72ff));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    op(8'h9f);
    host.xfer(0, 32, 1, 1, r);
    host.sel(1'b0);
    chk(r, {MFR, MEM, CAP, MFR}, "id3");
    for (int i = 0; i < 6; i++) begin
      ln = 1 << (i / 2);
      op(ids[i / 2]);
      host.xfer(32'(i % 2), 24 / ln, ln, 0, r);
      host.xfer(0, ln == 1 ? 0 : ln + 2, ln, 0, r);
      host.xfer(0, 32 / ln, ln, 1, r);
      chk(dq_oe_n, ln == 1 ? 4'hd : ln == 2 ? 4'hc : 4'h0, "oe");
      host.sel(1'b0);
      chk(r, {2{id_pair(i % 2)}}, "id");
      chk(dq_oe_n, 4'hf, "oe idle");
    end
    for (int a = 0; a < 3; a++) begin
      erase(a, 0, 1);
      op(a ? OP_OTP_READ : 8'h9f);
      host.slow = 1'b0;
      host.xfer(0, 24, 1, 0, r);
      chk(dq_oe_n, 4'hf, "busy oe");
      host.sel(1'b0);
      settle(1, 0);
      for (int k = 0; k < 512; k++) mem[a][k] = ERASED_BYTE;
    end
    for (int a = 0; a < 3; a++) begin
      col = a ? 9'($urandom) : 9'h0fe;
      prog(a, col, 1 + $urandom % 4);
      settle(1, 0);
      rd(a, col);
    end
    erase(1, 1, 1);
    settle(0, 1);
    @(posedge sys_clk);
    otp_lock_bits <= 3'h4;
    prog(2, 9'h010, 2);
    settle(0, 1);
    rd(2, 9'h010);
    erase(2, 0, 1);
    settle(0, 1);
    rd(2, 9'h010);
    erase(1, 0, 1);
    // A low clock enable must hold the erase past its normal end
    @(posedge sys_clk);
    clk_en <= 1'b0;
    repeat (600) @(posedge sys_clk);
    chk(write_in_progress_flag, 1, "frozen busy");
    clk_en <= 1'b1;
    settle(1, 0);
    for (int k = 0; k < 512; k++) mem[1][k] = ERASED_BYTE;
    erase(0, 0, 0);
    settle(0, 0);
    rd(0, 9'h0fe);
    wrap_up();
  end
endmodule // tb_top
